// ### logic/rilmb_buffer.v
/*
  Buffer memory and error-reset logic of a serial remote I/O link master.
  Holds initial data, transmit data, card data, fault bitmaps and error
  codes, streams transmit bytes per station through a FIFO and reacts to
  per-station poll results from the link engine.
  Assumes the host port, control requests and link engine run on clk; the
  two mode switches come from pins and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rilmb_map.vh"

module rilmb_buffer (
  input wire clk,
  input wire rstn,
  input wire [7:0] host_addr,
  input wire host_wr,
  input wire host_rd,
  input wire [15:0] host_wdata,
  output reg [15:0] host_rdata,
  output reg host_rvalid,
  output wire host_busy,
  input wire link_run_request,
  input wire error_clear_request,
  input wire faulty_rx_clear_select,
  input wire auto_return_pin,
  input wire stop_on_fault_pin,
  output reg rx_error_flag,
  output reg link_stop_error_flag,
  output wire link_active,
  output reg line_error_led,
  output reg faulty_station_led,
  output reg faulty_rx_clear,
  input wire [127:0] card_map,
  input wire poll_done,
  input wire [5:0] poll_station,
  input wire poll_ok,
  input wire line_break,
  output wire tx_valid,
  input wire tx_ready,
  output wire [5:0] tx_station,
  output wire [7:0] tx_byte,
  output reg fwd_rotation_cmd,
  output reg rev_rotation_cmd,
  output reg low_speed_sel,
  output reg mid_speed_sel,
  output reg high_speed_sel,
  output reg second_accel_sel,
  output reg output_halt_cmd
);

  // One-hot states of the controller.
  localparam ST_INIT = 5'b00001;
  localparam ST_IDLE = 5'b00010;
  localparam ST_START = 5'b00100;
  localparam ST_RUN = 5'b01000;
  localparam ST_STOP = 5'b10000;

  // Host-writable memory, words 0 to 41; words 2 to 9 are reserved.
  reg [15:0] mem [0:`RILMB_MEM_WORDS-1];
  // Controller state and its next value.
  reg [4:0] state;
  reg [4:0] next_state;
  // Address walker that clears the memory after reset.
  reg [5:0] clr_addr;
  // Last level of the link run request, for its rising edge.
  reg run_last;
  // Station count and retry limit captured at the link run edge.
  reg [6:0] run_stations;
  reg [5:0] run_retries;
  // Card data, two bits per station, station 1 in bits 1:0.
  reg [127:0] card;
  // Sticky and current fault bitmaps, station 1 at bit 0.
  reg [63:0] sticky_fault;
  reg [63:0] current_fault;
  // Error code words.
  reg [15:0] comm_err_code;
  reg [15:0] err_det_code;
  // Retry counters of all stations.
  reg [5:0] retry_cnt [0:63];
  // Refresh pointer, zero-based station index.
  reg [5:0] refresh_idx;
  integer i;

  // Mode switches after synchronisation.
  wire auto_return;
  wire stop_on_fault;

  // Returns the selected 16-bit word of a wide bitmap.
  function [15:0] pick_word;
    input [127:0] map;
    input [2:0] idx;
    begin
      pick_word = map[{idx, 4'h0} +: 16];
    end
  endfunction

  // True when a word address lies within an inclusive range.
  function in_range;
    input [7:0] addr;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_range = (addr >= lo) && (addr <= hi);
    end
  endfunction

  rilmb_sync u_sync_auto (
    .clk(clk),
    .rstn(rstn),
    .din(auto_return_pin),
    .dout(auto_return)
  );

  rilmb_sync u_sync_stop (
    .clk(clk),
    .rstn(rstn),
    .din(stop_on_fault_pin),
    .dout(stop_on_fault)
  );

  // Decoded events of the control requests.
  wire run_rise = link_run_request && !run_last;
  wire clear_ok = error_clear_request && !link_run_request && !state[0];
  // Validity of the initial data as the host left it.
  wire stations_ok = (mem[0] >= `RILMB_STATIONS_MIN) && (mem[0] <= `RILMB_STATIONS_MAX);
  wire retries_ok = (mem[1] <= `RILMB_RETRIES_MAX);
  // A poll result counts only while the link runs and run is still
  // requested, so an error clear can never meet a fresh poll or line error event.
  wire poll_seen = state[3] && link_run_request && poll_done;
  wire poll_bad = poll_seen && !poll_ok;
  wire [6:0] next_retry = {1'b0, retry_cnt[poll_station]} + 7'h01;
  wire retry_spent = poll_bad && (next_retry > {1'b0, run_retries});
  wire fault_stop = retry_spent || (poll_bad && stop_on_fault);
  wire line_stop = state[3] && link_run_request && line_break;

  assign host_busy = state[0];
  assign link_active = state[3];

  // Next state: clear after reset, wait, check initial data, run, stop.
  always @* begin
    next_state = state;
    case (state)
      ST_INIT: begin
        if (clr_addr == `RILMB_MEM_LAST) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (run_rise) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        // An invalid station or retry count halts the link at once.
        if (stations_ok && retries_ok) begin
          next_state = ST_RUN;
        end else begin
          next_state = ST_STOP;
        end
      end
      ST_RUN: begin
        if (!link_run_request) begin
          next_state = ST_IDLE;
        end else if (line_stop || fault_stop) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        // A stopped link waits for the run request to drop.
        if (!link_run_request) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_INIT;
      end
    endcase
  end

  // State register, run edge detector and the memory clear walker.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_INIT;
      run_last <= 1'b0;
      clr_addr <= 6'h00;
    end else begin
      state <= next_state;
      // A run request still high when the clear ends counts as an edge; the host waits on busy.
      run_last <= state[0] ? 1'b0 : link_run_request;
      if (state[0]) begin
        clr_addr <= clr_addr + 6'h01;
      end
    end
  end

  // Memory writes: the walker owns the memory until the clear is done.
  always @(posedge clk) begin
    if (state[0]) begin
      if (clr_addr == `RILMB_MEM_LAST) begin
        mem[clr_addr] <= 16'h0000;
        // The walker clears word 1 at its second step, after word 0, so the default lands last.
        mem[1] <= `RILMB_RETRIES_RESET;
      end else begin
        mem[clr_addr] <= 16'h0000;
      end
    end else if (host_wr) begin
      // Writes outside the writable words are dropped silently.
      if (host_addr == `RILMB_ADDR_STATIONS || host_addr == `RILMB_ADDR_RETRIES ||
          in_range(host_addr, `RILMB_ADDR_TX_FIRST, `RILMB_ADDR_TX_LAST)) begin
        mem[host_addr[5:0]] <= host_wdata;
      end
    end
  end

  // Capture of the initial data and card data at the run edge.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_stations <= 7'h00;
      run_retries <= 6'h00;
      card <= 128'h0;
    end else if (state[1] && run_rise) begin
      // Later host writes leave the refresh set-up unchanged.
      run_stations <= mem[0][6:0];
      run_retries <= mem[1][5:0];
      // Card codes are fixed for the whole run.
      card <= card_map;
    end
  end

  // Fault bitmaps and retry counters.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sticky_fault <= 64'h0;
      current_fault <= 64'h0;
      for (i = 0; i < 64; i = i + 1) begin
        retry_cnt[i] <= 6'h00;
      end
    end else if (state[1] && run_rise) begin
      // A new run starts with a clean status region.
      sticky_fault <= 64'h0;
      current_fault <= 64'h0;
      for (i = 0; i < 64; i = i + 1) begin
        retry_cnt[i] <= 6'h00;
      end
    end else if (poll_seen) begin
      if (!poll_ok) begin
        sticky_fault[poll_station] <= 1'b1;
        current_fault[poll_station] <= 1'b1;
        retry_cnt[poll_station] <= next_retry[5:0];
      end else begin
        retry_cnt[poll_station] <= 6'h00;
        // Without automatic return the bit stays until the next run.
        if (auto_return) begin
          current_fault[poll_station] <= 1'b0;
        end
      end
    end
  end

  // Error codes, error flags and indicators.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      comm_err_code <= `RILMB_CERR_NONE;
      err_det_code <= 16'h0000;
      rx_error_flag <= 1'b0;
      link_stop_error_flag <= 1'b0;
      line_error_led <= 1'b0;
      faulty_station_led <= 1'b0;
    end else if (state[1] && run_rise) begin
      comm_err_code <= `RILMB_CERR_NONE;
      err_det_code <= 16'h0000;
      rx_error_flag <= 1'b0;
      link_stop_error_flag <= 1'b0;
      line_error_led <= 1'b0;
      faulty_station_led <= 1'b0;
    end else if (clear_ok) begin
      // No poll or line event can arrive here while run is off; a failed init check in this cycle is lost.
      comm_err_code <= `RILMB_CERR_NONE;
      err_det_code <= 16'h0000;
      rx_error_flag <= 1'b0;
      link_stop_error_flag <= 1'b0;
      line_error_led <= 1'b0;
      faulty_station_led <= 1'b0;
    end else if (state[2]) begin
      if (!(stations_ok && retries_ok)) begin
        comm_err_code <= `RILMB_CERR_INIT;
        link_stop_error_flag <= 1'b1;
      end
    end else if (state[3]) begin
      if (line_stop) begin
        comm_err_code <= `RILMB_CERR_LINE;
        link_stop_error_flag <= 1'b1;
        line_error_led <= 1'b1;
      end else if (fault_stop) begin
        comm_err_code <= `RILMB_CERR_FAULT;
        link_stop_error_flag <= 1'b1;
      end
      if (poll_bad) begin
        rx_error_flag <= 1'b1;
        err_det_code <= `RILMB_EDET_SET;
        faulty_station_led <= 1'b1;
      end else if (poll_seen && auto_return && (current_fault & ~(64'h1 << poll_station)) == 64'h0) begin
        // Automatic return drops the flag once no station is faulty,
        // but the detection code word keeps its 1.
        rx_error_flag <= 1'b0;
      end
    end
  end

  // Receive-data clearing choice is passed to the link engine as is; it
  // suits the no-automatic-return mode best.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      faulty_rx_clear <= 1'b0;
    end else begin
      faulty_rx_clear <= faulty_rx_clear_select;
    end
  end

  // Refresh stream: one byte per station, 1 up to the captured count.
  // An inverter simply takes four consecutive slots of this stream.
  // Full-width sum first; the top two bits are always zero for words 10 to 41.
  wire [7:0] tx_word_full = `RILMB_ADDR_TX_FIRST + {3'h0, refresh_idx[5:1]};
  wire [5:0] tx_word = tx_word_full[5:0];
  wire [7:0] refresh_byte = refresh_idx[0] ? mem[tx_word][15:8] : mem[tx_word][7:0];
  wire fifo_in_ready;
  wire fifo_in_valid = state[3];
  wire [13:0] fifo_out;

  // The pointer stalls whenever the FIFO is full, so back-pressure from
  // the link engine holds the refresh rather than dropping bytes.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      refresh_idx <= 6'h00;
    end else if (!state[3]) begin
      refresh_idx <= 6'h00;
    end else if (fifo_in_ready) begin
      if ({1'b0, refresh_idx} + 7'h01 >= run_stations) begin
        refresh_idx <= 6'h00;
      end else begin
        refresh_idx <= refresh_idx + 6'h01;
      end
    end
  end

  rilmb_fifo #(
    .WIDTH(`RILMB_FIFO_WIDTH),
    .AW(`RILMB_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({refresh_idx, refresh_byte}),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(fifo_out)
  );

  assign tx_station = fifo_out[13:8];
  assign tx_byte = fifo_out[7:0];

  // Last byte sent to a command slot (second slot of an odd-based
  // inverter) decoded into drive functions; bit 0 is ignored.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fwd_rotation_cmd <= 1'b0;
      rev_rotation_cmd <= 1'b0;
      low_speed_sel <= 1'b0;
      mid_speed_sel <= 1'b0;
      high_speed_sel <= 1'b0;
      second_accel_sel <= 1'b0;
      output_halt_cmd <= 1'b0;
    end else if (tx_valid && tx_ready && tx_station[1:0] == 2'b01) begin
      fwd_rotation_cmd <= tx_byte[1];
      rev_rotation_cmd <= tx_byte[2];
      low_speed_sel <= tx_byte[3];
      mid_speed_sel <= tx_byte[4];
      high_speed_sel <= tx_byte[5];
      second_accel_sel <= tx_byte[6];
      output_halt_cmd <= tx_byte[7];
    end
  end

  // Host reads: one word per request, answered on the next edge; any
  // address may be read, so a block read walks across regions freely.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_rdata <= 16'h0000;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_rd;
      if (host_rd) begin
        if (host_addr <= `RILMB_ADDR_TX_LAST) begin
          host_rdata <= mem[host_addr[5:0]];
        end else if (in_range(host_addr, `RILMB_ADDR_CARD_FIRST, `RILMB_ADDR_CARD_LAST)) begin
          host_rdata <= pick_word(card, host_addr[2:0] - 3'h6);
        end else if (in_range(host_addr, `RILMB_ADDR_STICKY_FIRST, `RILMB_ADDR_STICKY_LAST)) begin
          host_rdata <= pick_word({64'h0, sticky_fault}, host_addr[2:0] - 3'h2);
        end else if (in_range(host_addr, `RILMB_ADDR_CURR_FIRST, `RILMB_ADDR_CURR_LAST)) begin
          host_rdata <= pick_word({64'h0, current_fault}, host_addr[2:0] - 3'h4);
        end else if (host_addr == `RILMB_ADDR_COMM_ERR) begin
          host_rdata <= comm_err_code;
        end else if (host_addr == `RILMB_ADDR_ERR_DET) begin
          host_rdata <= err_det_code;
        end else begin
          // Reserved and left-out words read as zero.
          host_rdata <= 16'h0000;
        end
      end
    end
  end

endmodule // rilmb_buffer

`default_nettype wire

// ### logic/rilmb_fifo.v
/*
  Synchronous FIFO with valid/ready on both sides; width and depth are
  parameters, depth a power of two given by its address width.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module rilmb_fifo #(
  parameter WIDTH = 14,
  parameter AW = 3
) (
  input wire clk,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  localparam DEPTH = 1 << AW;

  // Storage; the read side takes the word straight out of the array.
  reg [WIDTH-1:0] store [0:DEPTH-1];
  // Pointers carry one extra bit to tell full from empty.
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;

  wire empty = (wr_ptr == rd_ptr);
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = store[rd_ptr[AW-1:0]];

  // The array holds no reset; only pointers define the contents.
  always @(posedge clk) begin
    if (in_valid && !full) begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers advance on each accepted push and pop.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule // rilmb_fifo

`default_nettype wire

// ### logic/rilmb_map.vh
/*
  Constants of the remote I/O link master buffer: word addresses of the
  buffer memory, reset values, limits of the initial data, error codes and
  the shape of the transmit FIFO.
  Assumes it is included by bare name from files of the rilmb block.
*/
`ifndef RILMB_MAP_VH
`define RILMB_MAP_VH

// Word addresses of the buffer memory.
`define RILMB_ADDR_STATIONS 8'h00
`define RILMB_ADDR_RETRIES 8'h01
`define RILMB_ADDR_TX_FIRST 8'h0a
`define RILMB_ADDR_TX_LAST 8'h29
`define RILMB_ADDR_CARD_FIRST 8'h46
`define RILMB_ADDR_CARD_LAST 8'h4d
`define RILMB_ADDR_STICKY_FIRST 8'h5a
`define RILMB_ADDR_STICKY_LAST 8'h5d
`define RILMB_ADDR_CURR_FIRST 8'h64
`define RILMB_ADDR_CURR_LAST 8'h67
`define RILMB_ADDR_COMM_ERR 8'h6b
`define RILMB_ADDR_ERR_DET 8'h6c

// Size of the host-writable memory, words 0 to 41.
`define RILMB_MEM_WORDS 42
`define RILMB_MEM_LAST 6'h29

// Reset values and limits of the initial data.
`define RILMB_STATIONS_RESET 16'h0000
`define RILMB_RETRIES_RESET 16'h0002
`define RILMB_STATIONS_MIN 16'h0001
`define RILMB_STATIONS_MAX 16'h0040
`define RILMB_RETRIES_MAX 16'h0020

// Communication error codes.
`define RILMB_CERR_NONE 16'h0000
`define RILMB_CERR_INIT 16'h0001
`define RILMB_CERR_LINE 16'h0002
`define RILMB_CERR_FAULT 16'h0003

// Error detection code value once a receive error was seen.
`define RILMB_EDET_SET 16'h0001

// Transmit FIFO: 6-bit station index plus one data byte, eight entries.
`define RILMB_FIFO_WIDTH 14
`define RILMB_FIFO_DEPTH 8
`define RILMB_FIFO_AW 3

`endif

// ### logic/rilmb_sync.v
/*
  Two-stage synchroniser for one level that arrives from a pin.
  Assumes clk is the block clock and rstn an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module rilmb_sync (
  input wire clk,
  input wire rstn,
  input wire din,
  output reg dout
);

  // First stage; read only by the second stage below.
  reg meta;

  // Both stages reset to zero so the synchronised level starts inactive.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // rilmb_sync

`default_nettype wire

// ### tb/rilmb_buffer_checker.sv
/* Port checker of the link master buffer.
   Assumes it is bound to rilmb_buffer: one clock, reset async active low. */
`timescale 1ns/1ps
`default_nettype none
module rilmb_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic host_rd,
  input wire logic host_busy,
  input wire logic host_rvalid,
  input wire logic link_run_request,
  input wire logic error_clear_request,
  input wire logic rx_error_flag,
  input wire logic link_stop_error_flag,
  input wire logic link_active,
  input wire logic line_error_led,
  input wire logic faulty_station_led,
  input wire logic poll_done,
  input wire logic poll_ok,
  input wire logic line_break,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic fwd_rotation_cmd,
  input wire logic output_halt_cmd,
  input wire logic [5:0] tx_station,
  input wire logic [7:0] tx_byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [7:0] busy_cnt; // Busy cycles since reset; saturates.
  // The clear walk must end, or the host is locked out for good.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) busy_cnt <= 8'h00;
    else if (host_busy && busy_cnt != 8'hff) busy_cnt <= busy_cnt + 8'h01;
  end
  busy_len_a: assert property (busy_cnt <= 8'h2b) else $error("clear walk too long");
  rd_answer_a: assert property (host_rd && !host_busy |=> host_rvalid) else $error("read unanswered");
  rd_only_a: assert property (!(host_rd && !host_busy) |=> !host_rvalid) else $error("stray answer");
  clr_ok_a: assert property (error_clear_request && !link_run_request && !host_busy && !link_active
    |=> !rx_error_flag && !link_stop_error_flag && !line_error_led && !faulty_station_led)
    else $error("clear ignored");
  clr_refuse_a: assert property (link_run_request && $past(link_run_request) && link_stop_error_flag
    |=> link_stop_error_flag) else $error("clear taken in run");
  run_start_a: assert property ($rose(link_run_request) && !host_busy && !link_active && !link_stop_error_flag
    |-> ##2 (link_active || link_stop_error_flag)) else $error("start late");
  poll_bad_a: assert property (link_active && link_run_request && poll_done && !poll_ok
    |=> rx_error_flag && faulty_station_led) else $error("fault missed");
  brk_stop_a: assert property (link_active && link_run_request && line_break
    |=> link_stop_error_flag && line_error_led ##1 !link_active) else $error("break missed");
  tx_hold_a: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_station) && $stable(tx_byte)) else $error("tx word lost");
  cmd_dec_a: assert property (tx_valid && tx_ready && tx_station[1:0] == 2'h1
    |=> fwd_rotation_cmd == $past(tx_byte[1]) && output_halt_cmd == $past(tx_byte[7]))
    else $error("command decode");
endmodule // rilmb_checker
bind rilmb_buffer rilmb_checker i_rilmb_checker (.*);
`default_nettype wire

// ### tb/rilmb_link_model.sv
/* Link engine side model: takes transmit words, keeps the last byte per
   station. Assumes the tx port of rilmb_buffer on clk. */
`timescale 1ns/1ps
`default_nettype none
module rilmb_link_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [5:0] tx_station,
  input wire logic [7:0] tx_byte,
  output logic tx_ready
);
  logic [7:0] seen [0:63]; // Last byte taken per station index.
  logic [5:0] top; // Highest station index taken.
  logic [1:0] ph; // Phase of the slow sink.
  // A slow sink takes one word in four, so the FIFO fills and refuses.
  assign tx_ready = rstn && (!slow || ph == 2'h3);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph <= 2'h0;
      top <= 6'h00;
    end else begin
      ph <= ph + 2'h1;
      if (tx_valid && tx_ready) begin
        seen[tx_station] <= tx_byte;
        if (tx_station > top) top <= tx_station;
      end
    end
  end
endmodule // rilmb_link_model
`default_nettype wire

// ### tb/tb_rilmb_buffer.sv
/* Self-checking bench of the link master buffer.
   Assumes rilmb_buffer, the link model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_rilmb_buffer;
  logic clk = 1'h0, rstn = 1'h0, host_wr = 1'h0, host_rd = 1'h0, host_rvalid, host_busy;
  logic link_run_request = 1'h0, error_clear_request = 1'h0, faulty_rx_clear_select = 1'h0;
  logic auto_return_pin = 1'h1, stop_on_fault_pin = 1'h0, rx_error_flag, link_stop_error_flag;
  logic link_active, line_error_led, faulty_station_led, faulty_rx_clear, slow = 1'h0;
  logic poll_done = 1'h0, poll_ok = 1'h0, line_break = 1'h0, tx_valid, tx_ready;
  logic fwd_rotation_cmd, rev_rotation_cmd, low_speed_sel, mid_speed_sel;
  logic high_speed_sel, second_accel_sel, output_halt_cmd;
  logic [7:0] host_addr = 8'h00, tx_byte;
  logic [15:0] host_wdata = 16'h0000, host_rdata;
  logic [5:0] poll_station = 6'h00, tx_station;
  logic [127:0] card_map = {8{16'h9a61}};
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  rilmb_buffer i_rilmb_buffer (.*);
  rilmb_link_model i_rilmb_link_model (.*);
  always #50 clk = ~clk;
  // Cuts a hang short; the whole run needs far fewer cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      stop_test();
    end
  end
  task stop_test;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Bus strobes rise at a falling edge and drop at the next one.
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'h1;
    @(negedge clk);
    host_wr = 1'h0;
  endtask
  // The answer is due in the cycle right after the taking edge.
  task rdw(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk);
    host_addr = a;
    host_rd = 1'h1;
    @(negedge clk);
    host_rd = 1'h0;
    chk(host_rvalid, 16'h0001);
    chk(host_rdata, exp);
  endtask
  task poll(input logic [5:0] s, input logic ok);
    @(negedge clk);
    poll_station = s;
    poll_ok = ok;
    poll_done = 1'h1;
    @(negedge clk);
    poll_done = 1'h0;
  endtask
  task clr;
    @(negedge clk);
    error_clear_request = 1'h1;
    @(negedge clk);
    error_clear_request = 1'h0;
  endtask
  task run(input logic v);
    @(negedge clk);
    link_run_request = v;
    repeat (3) @(negedge clk);
  endtask
  task t_reset;
    rdw(8'h00, 16'h0000);
    rdw(8'h01, 16'h0002);
    rdw(8'h0a, 16'h0000);
    wr(8'h02, 16'h1234);
    rdw(8'h02, 16'h0000);
    wr(8'h5a, 16'hffff);
    rdw(8'h5a, 16'h0000);
    wr(8'h00, 16'h0004);
    wr(8'h0a, 16'haa11);
    wr(8'h0b, 16'h4433);
    rdw(8'h0a, 16'haa11);
  endtask
  task t_stream;
    slow = 1'h1;
    run(1'h1);
    chk(link_active, 16'h0001);
    card_map = 128'h0;
    wr(8'h00, 16'h0002);
    repeat (80) @(negedge clk);
    chk(i_rilmb_link_model.top, 16'h0003);
    chk({i_rilmb_link_model.seen[1], i_rilmb_link_model.seen[0]}, 16'haa11);
    chk({i_rilmb_link_model.seen[3], i_rilmb_link_model.seen[2]}, 16'h4433);
    chk({fwd_rotation_cmd, rev_rotation_cmd, low_speed_sel, mid_speed_sel,
      high_speed_sel, second_accel_sel, output_halt_cmd}, 16'h0055);
    rdw(8'h46, 16'h9a61);
    slow = 1'h0;
  endtask
  task t_faults;
    poll(6'h02, 1'h0);
    chk(rx_error_flag, 16'h0001);
    rdw(8'h64, 16'h0004);
    poll(6'h02, 1'h1);
    chk(rx_error_flag, 16'h0000);
    rdw(8'h64, 16'h0000);
    rdw(8'h5a, 16'h0004);
    rdw(8'h6c, 16'h0001);
    poll(6'h03, 1'h0);
    poll(6'h03, 1'h0);
    chk(link_stop_error_flag, 16'h0000);
    poll(6'h03, 1'h0);
    chk(link_stop_error_flag, 16'h0001);
    rdw(8'h6b, 16'h0003);
  endtask
  task t_clear;
    clr();
    chk(link_stop_error_flag, 16'h0001);
    run(1'h0);
    clr();
    chk({rx_error_flag, link_stop_error_flag, line_error_led, faulty_station_led}, 16'h0000);
    rdw(8'h6b, 16'h0000);
    rdw(8'h6c, 16'h0000);
  endtask
  task t_init;
    logic [15:0] cfg [0:5];
    cfg = '{16'h0000, 16'h0002, 16'h0041, 16'h0002, 16'h0004, 16'h0021};
    for (int i = 0; i < 6; i += 2) begin
      wr(8'h00, cfg[i]);
      wr(8'h01, cfg[i+1]);
      run(1'h1);
      chk(link_stop_error_flag, 16'h0001);
      rdw(8'h6b, 16'h0001);
      run(1'h0);
      clr();
    end
    wr(8'h00, 16'h0040);
    wr(8'h01, 16'h0020);
    run(1'h1);
    chk(link_active, 16'h0001);
    rdw(8'h5a, 16'h0000);
    rdw(8'h64, 16'h0000);
    auto_return_pin = 1'h0;
    faulty_rx_clear_select = 1'h1;
    poll(6'h04, 1'h0);
    chk(faulty_rx_clear, 16'h0001);
    poll(6'h04, 1'h1);
    chk(rx_error_flag, 16'h0001);
    rdw(8'h64, 16'h0010);
    @(negedge clk) line_break = 1'h1;
    @(negedge clk) line_break = 1'h0;
    chk(line_error_led, 16'h0001);
    rdw(8'h6b, 16'h0002);
    run(1'h0);
    clr();
    poll(6'h01, 1'h0);
    chk(rx_error_flag, 16'h0000);
    stop_on_fault_pin = 1'h1;
    run(1'h1);
    poll(6'h05, 1'h0);
    chk(link_stop_error_flag, 16'h0001);
    rdw(8'h6b, 16'h0003);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rstn = 1'h1;
    for (int i = 0; i < 60 && host_busy !== 1'h0; i++) @(negedge clk);
    chk(host_busy, 16'h0000);
    t_reset();
    t_stream();
    t_faults();
    t_clear();
    t_init();
    stop_test();
  end
endmodule // tb_rilmb_buffer
`default_nettype wire
